// ==== core/flmc_defines.svh ====
// constants for the flash mode entry and exit control block
`ifndef FLMC_DEFINES_SVH
`define FLMC_DEFINES_SVH

// instruction codes
`define FLMC_OP_WRSR 8'h01
`define FLMC_OP_RDSR1 8'h05
`define FLMC_OP_WREN 8'h06
`define FLMC_OP_RDSR2 8'h35
`define FLMC_OP_RDCFG 8'h65
`define FLMC_OP_WRCFG 8'h71
`define FLMC_OP_QREAD 8'hEB
`define FLMC_OP_QREAD4 8'hEC
`define FLMC_OP_EN4B 8'hB7
`define FLMC_OP_EX4B 8'hE9
`define FLMC_OP_RSTEN 8'h66
`define FLMC_OP_RST 8'h99

// mode byte and configuration byte
`define FLMC_MODE_ENTER 8'hA5
`define FLMC_MODE_KEEP_HI 4'hA
`define FLMC_CFG_ADDR 32'h0080_0003
`define FLMC_CFG_QPI_BIT 6
`define FLMC_SR2_QUAD_EN_BIT 1
`define FLMC_FH_NIBBLE 4'hF
`define FLMC_FH_CLOCKS 4'h8

// phase lengths in bits
`define FLMC_CMD_BITS 6'h08
`define FLMC_A3_BITS 6'h18
`define FLMC_A4_BITS 6'h20
`define FLMC_MODE_BITS 6'h08
`define FLMC_WRSR_BITS 6'h10
`define FLMC_CFG_BITS 6'h08

// discoverable parameter words
`define FLMC_SFDP_DW15 32'hFF5D_F68C
`define FLMC_SFDP_DW16 32'h41F8_30F0

// apb register map
`define FLMC_REG_STATUS 12'h000
`define FLMC_REG_CTRL 12'h004
`define FLMC_REG_DW15 12'h008
`define FLMC_REG_DW16 12'h00C
`define FLMC_CTRL_PWR_BIT 0
`define FLMC_CTRL_EN_BIT 1
`define FLMC_CTRL_RST 2'h2
`define FLMC_STAT_QUAD_EN 0
`define FLMC_STAT_CONT 1
`define FLMC_STAT_A4 2
`define FLMC_STAT_QPI 3
`define FLMC_STAT_WEL 4
`define FLMC_STAT_RSTEN 5
`define FLMC_STAT_SR1_LSB 8

// synchroniser reset value: hw reset pin and chip select idle high
`define FLMC_SYNC_RST 7'h60

`endif

// ==== core/flmc_pkg.sv ====
// types shared by the flash mode entry and exit control block
package flmc_pkg;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_CMD = 3'b001,
    ST_ADDR = 3'b010,
    ST_MODE = 3'b011,
    ST_DATA = 3'b100,
    ST_OUT = 3'b101,
    ST_SKIP = 3'b110
  } flmc_state_t;

  typedef enum logic [3:0] {
    OP_NONE = 4'h0,
    OP_WRSR = 4'h1,
    OP_RDSR = 4'h2,
    OP_WREN = 4'h3,
    OP_RDCFG = 4'h4,
    OP_WRCFG = 4'h5,
    OP_QREAD = 4'h6,
    OP_EN4B = 4'h7,
    OP_EX4B = 4'h8,
    OP_RSTEN = 4'h9,
    OP_RST = 4'hA
  } flmc_op_t;

  typedef struct packed {
    logic hw_rst_n;
    logic cs_n;
    logic sck;
    logic [3:0] dq;
  } flmc_link_t;

  typedef struct packed {
    logic rst_en;
    logic wel;
    logic qpi;
    logic addr4;
    logic cont;
    logic quad_enable_bit;
  } flmc_mode_t;

endpackage

// ==== core/flmc_sync.sv ====
// two flip-flop synchroniser, one stage pair per bit
`timescale 1ns/1ps
`default_nettype none

module flmc_sync #(
  parameter int W = 7,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);

  genvar gi;
  generate
    for (gi = 0; gi < W; gi++) begin : g_bit
      logic meta_ff;
      logic sync_ff;
      always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          meta_ff <= RST_VAL[gi];
          sync_ff <= RST_VAL[gi];
        end else begin
          meta_ff <= d_i[gi];
          sync_ff <= meta_ff;
        end
      end
      assign q_o[gi] = sync_ff;
    end
  endgenerate

endmodule

`default_nettype wire

// ==== core/flmc_shift.sv ====
// serial input shifter, one or four lanes per serial clock
`timescale 1ns/1ps
`default_nettype none

module flmc_shift (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic clr_i,
  input wire logic shift_i,
  input wire logic quad_i,
  input wire logic [3:0] din_i,
  output logic [31:0] word_o,
  output logic [5:0] nbits_o
);

  logic [31:0] word_ff;
  logic [5:0] nbits_ff;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      word_ff <= 32'h0000_0000;
      nbits_ff <= 6'h00;
    end else if (clr_i) begin
      word_ff <= 32'h0000_0000;
      nbits_ff <= 6'h00;
    end else if (shift_i) begin
      if (quad_i) begin
        word_ff <= {word_ff[27:0], din_i};
        nbits_ff <= nbits_ff + 6'h04;
      end else begin
        word_ff <= {word_ff[30:0], din_i[0]};
        nbits_ff <= nbits_ff + 6'h01;
      end
    end
  end

  assign word_o = word_ff;
  assign nbits_o = nbits_ff;

endmodule

`default_nettype wire

// ==== core/flmc_top.sv ====
// serial flash mode entry and exit control with apb status access
//
// Overview of operation
// - write status with two bytes sets quad enable when byte two bit 1 is one
// - write status with two bytes clears quad enable when that bit is zero
// - mode byte A5h enters continuous quad read; quad enable must be set
// - mode byte 00h ends continuous mode when the current read completes
// - all ones on four data lines for eight clocks exits continuous mode
// - mode byte whose upper nibble is not A leaves continuous mode
// - quad protocol enabled by setting config bit 6 at 800003h via 65h then 71h
// - quad protocol disabled by clearing that bit with the same sequence
// - quad protocol selection is volatile and lost over power loss
// - instruction B7h enters four byte addressing without write enable
// - dedicated instructions always carry four byte addresses; continuous frames after ECh use three unless B7h mode is set
// - hardware reset, software reset and power cycle restore three byte addressing
// - software reset happens only on 66h followed directly by 99h
// - reset pair accepted on one or four wires per current mode
// - status register 1 write needs preceding write enable 06h
// - parameter dword fifteen reads FF5DF68Ch
// - parameter dword sixteen reads 41F830F0h
// - quad enable is bit 1 of status 2 read by 35h; status 1 by 05h
//
// The register offsets and the APB slave port are this design's own decisions.
`include "flmc_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module flmc_top
  import flmc_pkg::*;
(
  input wire logic MCLK_I,
  input wire logic RST_N_I,
  input wire logic HW_RST_N_I,
  input wire logic SCK_I,
  input wire logic CS_N_I,
  input wire logic [3:0] DQ_I,
  output logic [3:0] DQ_O,
  output logic [3:0] DQ_OE_O,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [11:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  output logic QUAD_ENABLE_O,
  output logic CONT_MODE_O,
  output logic ADDR4_O,
  output logic QPI_O
);

  // ----------------------------------------------------------------
  // pin synchronisers and edge detection
  // ----------------------------------------------------------------
  logic [6:0] sync_q;
  flmc_link_t lnk;
  logic sck_q_ff;
  logic cs_q_ff;
  logic sck_rise;
  logic sck_fall;
  logic frame_start;
  logic frame_end;

  flmc_sync #(.W(7), .RST_VAL(`FLMC_SYNC_RST)) u_sync (
    .clk_i(MCLK_I),
    .rst_n_i(RST_N_I),
    .d_i({HW_RST_N_I, CS_N_I, SCK_I, DQ_I}),
    .q_o(sync_q)
  );

  assign lnk = flmc_link_t'(sync_q);

  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      sck_q_ff <= 1'b0;
      cs_q_ff <= 1'b1;
    end else begin
      sck_q_ff <= lnk.sck;
      cs_q_ff <= lnk.cs_n;
    end
  end

  assign sck_rise = lnk.sck & ~sck_q_ff & ~lnk.cs_n;
  assign sck_fall = ~lnk.sck & sck_q_ff & ~lnk.cs_n;
  assign frame_start = ~lnk.cs_n & cs_q_ff;
  assign frame_end = lnk.cs_n & ~cs_q_ff;

  // ----------------------------------------------------------------
  // state, apb-facing registers
  // ----------------------------------------------------------------
  flmc_state_t state_ff;
  flmc_state_t nxt_state;
  flmc_op_t op_ff;
  flmc_op_t nxt_op;
  flmc_mode_t mode_ff;
  logic [7:0] sr1_ff;
  logic done_ff;
  logic quad_ff;
  logic [5:0] need_ff;
  logic [31:0] addr_ff;
  logic [15:0] data_ff;
  logic [7:0] mbyte_ff;
  logic [7:0] out_ff;
  logic [3:0] ones_ff;
  logic fh_exit_ff;
  logic [1:0] ctrl_ff;
  logic pwr_pulse_ff;
  logic vol_clr;
  logic soft_rst;
  logic [31:0] word;
  logic [5:0] nbits;
  logic shifting;
  logic phase_done;
  logic [7:0] opc;

  assign opc = word[7:0];
  assign shifting = (state_ff == ST_CMD) || (state_ff == ST_ADDR) ||
                    (state_ff == ST_MODE) || (state_ff == ST_DATA);
  assign phase_done = shifting && (nbits == need_ff);

  flmc_shift u_shift (
    .clk_i(MCLK_I),
    .rst_n_i(RST_N_I),
    .clr_i(frame_start | phase_done),
    .shift_i(sck_rise & shifting),
    .quad_i(quad_ff),
    .din_i(lnk.dq),
    .word_o(word),
    .nbits_o(nbits)
  );

  // ----------------------------------------------------------------
  // instruction decode
  // ----------------------------------------------------------------
  always_comb begin
    nxt_op = OP_NONE;
    nxt_state = ST_SKIP;
    unique case (opc)
      `FLMC_OP_WRSR: begin
        nxt_op = OP_WRSR;
        nxt_state = ST_DATA;
      end
      `FLMC_OP_RDSR1, `FLMC_OP_RDSR2: begin
        nxt_op = OP_RDSR;
        nxt_state = ST_OUT;
      end
      `FLMC_OP_WREN: nxt_op = OP_WREN;
      `FLMC_OP_RDCFG: begin
        nxt_op = OP_RDCFG;
        nxt_state = ST_ADDR;
      end
      `FLMC_OP_WRCFG: begin
        nxt_op = OP_WRCFG;
        nxt_state = ST_ADDR;
      end
      `FLMC_OP_QREAD, `FLMC_OP_QREAD4: begin
        nxt_op = OP_QREAD;
        nxt_state = ST_ADDR;
      end
      `FLMC_OP_EN4B: nxt_op = OP_EN4B;
      `FLMC_OP_EX4B: nxt_op = OP_EX4B;
      `FLMC_OP_RSTEN: nxt_op = OP_RSTEN;
      `FLMC_OP_RST: nxt_op = OP_RST;
      default: nxt_op = OP_NONE;
    endcase
  end

  // ----------------------------------------------------------------
  // frame sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      state_ff <= ST_IDLE;
      op_ff <= OP_NONE;
      done_ff <= 1'b0;
      quad_ff <= 1'b0;
      need_ff <= `FLMC_CMD_BITS;
      addr_ff <= 32'h0000_0000;
      data_ff <= 16'h0000;
      mbyte_ff <= 8'h00;
      out_ff <= 8'h00;
    end else if (frame_end || vol_clr) begin
      state_ff <= ST_IDLE;
      done_ff <= 1'b0;
    end else if (frame_start) begin
      done_ff <= 1'b0;
      if (!ctrl_ff[`FLMC_CTRL_EN_BIT]) begin
        state_ff <= ST_SKIP;
        op_ff <= OP_NONE;
      end else if (mode_ff.cont) begin
        // no instruction in continuous mode: address comes first
        state_ff <= ST_ADDR;
        op_ff <= OP_QREAD;
        quad_ff <= 1'b1;
        need_ff <= mode_ff.addr4 ? `FLMC_A4_BITS : `FLMC_A3_BITS;
      end else begin
        state_ff <= ST_CMD;
        op_ff <= OP_NONE;
        quad_ff <= mode_ff.qpi;
        need_ff <= `FLMC_CMD_BITS;
      end
    end else if (phase_done) begin
      unique case (state_ff)
        ST_CMD: begin
          op_ff <= nxt_op;
          state_ff <= nxt_state;
          done_ff <= (nxt_state == ST_SKIP) || (nxt_state == ST_OUT);
          if (opc == `FLMC_OP_RDSR2) begin
            out_ff <= {6'h00, mode_ff.quad_enable_bit, 1'b0};
          end else begin
            out_ff <= {sr1_ff[7:2], mode_ff.wel, 1'b0};
          end
          if (nxt_op == OP_QREAD) begin
            quad_ff <= 1'b1;
          end
          if (nxt_op == OP_WRSR) begin
            need_ff <= `FLMC_WRSR_BITS;
          end else if (opc == `FLMC_OP_QREAD4) begin
            need_ff <= `FLMC_A4_BITS;
          end else begin
            need_ff <= mode_ff.addr4 ? `FLMC_A4_BITS : `FLMC_A3_BITS;
          end
        end
        ST_ADDR: begin
          addr_ff <= word;
          if (op_ff == OP_QREAD) begin
            state_ff <= ST_MODE;
            need_ff <= `FLMC_MODE_BITS;
          end else if (op_ff == OP_RDCFG) begin
            state_ff <= ST_OUT;
            done_ff <= 1'b1;
            out_ff <= 8'h00;
            if (word == `FLMC_CFG_ADDR) begin
              out_ff[`FLMC_CFG_QPI_BIT] <= mode_ff.qpi;
            end
          end else begin
            state_ff <= ST_DATA;
            need_ff <= `FLMC_CFG_BITS;
          end
        end
        ST_MODE: begin
          mbyte_ff <= word[7:0];
          state_ff <= ST_SKIP;
          done_ff <= 1'b1;
        end
        ST_DATA: begin
          data_ff <= word[15:0];
          state_ff <= ST_SKIP;
          done_ff <= 1'b1;
        end
        default: state_ff <= ST_SKIP;
      endcase
    end else if (state_ff == ST_OUT && sck_fall && !quad_ff) begin
      out_ff <= {out_ff[6:0], out_ff[7]};
    end else if (state_ff == ST_OUT && sck_fall) begin
      out_ff <= {out_ff[3:0], out_ff[7:4]};
    end
  end

  // ----------------------------------------------------------------
  // read data drive on falling serial clock
  // ----------------------------------------------------------------
  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      DQ_O <= 4'h0;
      DQ_OE_O <= 4'h0;
    end else if (state_ff != ST_OUT || lnk.cs_n) begin
      DQ_O <= 4'h0;
      DQ_OE_O <= 4'h0;
    end else if (sck_fall) begin
      if (quad_ff) begin
        DQ_O <= out_ff[7:4];
        DQ_OE_O <= 4'hF;
      end else begin
        DQ_O <= {2'h0, out_ff[7], 1'b0};
        DQ_OE_O <= 4'h2;
      end
    end
  end

  // ----------------------------------------------------------------
  // all-ones exit detector during continuous frames
  // ----------------------------------------------------------------
  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      ones_ff <= 4'h0;
      fh_exit_ff <= 1'b0;
    end else if (frame_start) begin
      ones_ff <= 4'h0;
      fh_exit_ff <= 1'b0;
    end else if (sck_rise && mode_ff.cont) begin
      if (lnk.dq != `FLMC_FH_NIBBLE) begin
        ones_ff <= `FLMC_FH_CLOCKS;
      end else if (ones_ff != `FLMC_FH_CLOCKS) begin
        ones_ff <= ones_ff + 4'h1;
        fh_exit_ff <= fh_exit_ff | (ones_ff == `FLMC_FH_CLOCKS - 4'h1);
      end
    end
  end

  // ----------------------------------------------------------------
  // mode state commit at chip select release; reset pin and power pulse clear at once
  // ----------------------------------------------------------------
  assign soft_rst = frame_end && done_ff && op_ff == OP_RST && mode_ff.rst_en;
  assign vol_clr = !lnk.hw_rst_n || pwr_pulse_ff || soft_rst;

  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      mode_ff <= '0;
      sr1_ff <= 8'h00;
    end else if (vol_clr) begin
      mode_ff.qpi <= 1'b0;
      mode_ff.addr4 <= 1'b0;
      mode_ff.cont <= 1'b0;
      mode_ff.wel <= 1'b0;
      mode_ff.rst_en <= 1'b0;
    end else if (frame_end && mode_ff.cont && fh_exit_ff) begin
      mode_ff.cont <= 1'b0;
    end else if (frame_end && done_ff) begin
      mode_ff.rst_en <= (op_ff == OP_RSTEN);
      unique case (op_ff)
        OP_WREN: mode_ff.wel <= 1'b1;
        OP_WRSR: begin
          if (mode_ff.wel) begin
            sr1_ff <= {data_ff[15:10], 2'h0};
            mode_ff.quad_enable_bit <= data_ff[`FLMC_SR2_QUAD_EN_BIT];
          end
          mode_ff.wel <= 1'b0;
        end
        OP_WRCFG: begin
          if (mode_ff.wel && addr_ff == `FLMC_CFG_ADDR) begin
            mode_ff.qpi <= data_ff[`FLMC_CFG_QPI_BIT];
          end
          mode_ff.wel <= 1'b0;
        end
        OP_EN4B: mode_ff.addr4 <= 1'b1;
        OP_EX4B: mode_ff.addr4 <= 1'b0;
        OP_QREAD: begin
          if (mbyte_ff == `FLMC_MODE_ENTER && mode_ff.quad_enable_bit) begin
            mode_ff.cont <= 1'b1;
          end else if (mbyte_ff[7:4] != `FLMC_MODE_KEEP_HI) begin
            mode_ff.cont <= 1'b0;
          end
        end
        default: mode_ff.wel <= mode_ff.wel;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // apb slave
  // ----------------------------------------------------------------
  logic apb_req;
  logic apb_wr_take;

  assign apb_req = PSEL_I & PENABLE_I & ~PREADY_O;
  assign apb_wr_take = PSEL_I & PENABLE_I & PREADY_O & PWRITE_I;

  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      PREADY_O <= 1'b0;
      PRDATA_O <= 32'h0000_0000;
      PSLVERR_O <= 1'b0;
    end else begin
      PREADY_O <= apb_req;
      if (apb_req) begin
        PSLVERR_O <= 1'b0;
        PRDATA_O <= 32'h0000_0000;
        unique case (PADDR_I)
          `FLMC_REG_STATUS: begin
            if (!PWRITE_I) begin
              PRDATA_O <= {16'h0000, sr1_ff, 2'h0, mode_ff.rst_en, mode_ff.wel,
                           mode_ff.qpi, mode_ff.addr4, mode_ff.cont, mode_ff.quad_enable_bit};
            end
          end
          `FLMC_REG_CTRL: begin
            if (!PWRITE_I) begin
              PRDATA_O <= {30'h0000_0000, ctrl_ff};
            end
          end
          `FLMC_REG_DW15: begin
            if (!PWRITE_I) begin
              PRDATA_O <= `FLMC_SFDP_DW15;
            end
          end
          `FLMC_REG_DW16: begin
            if (!PWRITE_I) begin
              PRDATA_O <= `FLMC_SFDP_DW16;
            end
          end
          default: PSLVERR_O <= 1'b1;
        endcase
      end
    end
  end

  // control: bit 0 pulses a power cycle, bit 1 enables command decode
  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      ctrl_ff <= `FLMC_CTRL_RST;
      pwr_pulse_ff <= 1'b0;
    end else begin
      pwr_pulse_ff <= 1'b0;
      if (apb_wr_take && PADDR_I == `FLMC_REG_CTRL) begin
        ctrl_ff[`FLMC_CTRL_EN_BIT] <= PWDATA_I[`FLMC_CTRL_EN_BIT];
        pwr_pulse_ff <= PWDATA_I[`FLMC_CTRL_PWR_BIT];
      end
    end
  end

  assign QUAD_ENABLE_O = mode_ff.quad_enable_bit;
  assign CONT_MODE_O = mode_ff.cont;
  assign ADDR4_O = mode_ff.addr4;
  assign QPI_O = mode_ff.qpi;

endmodule

`default_nettype wire

// ==== verif/flmc_top_asserts.sv ====
// concurrent checks on the mode control block ports
`timescale 1ns/1ps
`default_nettype none
`include "flmc_defines.svh"

module flmc_top_asserts (
  input wire logic MCLK_I,
  input wire logic RST_N_I,
  input wire logic HW_RST_N_I,
  input wire logic CS_N_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [11:0] PADDR_I,
  input wire logic [31:0] PRDATA_O,
  input wire logic PREADY_O,
  input wire logic PSLVERR_O,
  input wire logic [3:0] DQ_OE_O,
  input wire logic QUAD_ENABLE_O,
  input wire logic CONT_MODE_O,
  input wire logic ADDR4_O,
  input wire logic QPI_O
);
  default clocking cb @(posedge MCLK_I);
  endclocking
  default disable iff (!RST_N_I);

  chk_apb_wait: assert property (PSEL_I && PENABLE_I && !PREADY_O |=> PREADY_O)
    else $error("ready missing after one wait state");
  chk_ready_pulse: assert property (PREADY_O |=> !PREADY_O)
    else $error("ready held longer than one cycle");
  chk_dw15_read: assert property (PREADY_O && !PWRITE_I && PADDR_I == `FLMC_REG_DW15 |->
    PRDATA_O == `FLMC_SFDP_DW15 && !PSLVERR_O) else $error("parameter word 15 wrong");
  chk_dw16_read: assert property (PREADY_O && !PWRITE_I && PADDR_I == `FLMC_REG_DW16 |->
    PRDATA_O == `FLMC_SFDP_DW16 && !PSLVERR_O) else $error("parameter word 16 wrong");
  chk_status_mirror: assert property (PREADY_O && !PWRITE_I && PADDR_I == `FLMC_REG_STATUS |->
    PRDATA_O[3:0] == {QPI_O, ADDR4_O, CONT_MODE_O, QUAD_ENABLE_O}) else $error("status differs from mode pins");
  chk_mode_hold: assert property ((!CS_N_I && HW_RST_N_I && !PSEL_I) [*8] |->
    $stable({QPI_O, ADDR4_O, CONT_MODE_O, QUAD_ENABLE_O})) else $error("mode changed inside a frame");
  chk_cont_qe: assert property (CONT_MODE_O |-> QUAD_ENABLE_O)
    else $error("continuous mode without quad enable");
  chk_hwrst_clear: assert property (!HW_RST_N_I [*6] |-> !ADDR4_O && !QPI_O && !CONT_MODE_O)
    else $error("volatile modes kept through hardware reset");
  chk_oe_idle: assert property (CS_N_I [*6] |-> DQ_OE_O == 4'h0)
    else $error("data lines driven while deselected");
  chk_oe_shape: assert property (DQ_OE_O == 4'h0 || DQ_OE_O == 4'h2 || DQ_OE_O == 4'hF)
    else $error("unexpected lane enable pattern");
endmodule

bind flmc_top flmc_top_asserts u_flmc_top_asserts (.MCLK_I(MCLK_I), .RST_N_I(RST_N_I), .HW_RST_N_I(HW_RST_N_I),
  .CS_N_I(CS_N_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I),
  .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O), .DQ_OE_O(DQ_OE_O),
  .QUAD_ENABLE_O(QUAD_ENABLE_O), .CONT_MODE_O(CONT_MODE_O), .ADDR4_O(ADDR4_O), .QPI_O(QPI_O));
`default_nettype wire

// ==== verif/flmc_host_model.sv ====
// serial host model: mode 0 clock, one or four lanes, msb first
`timescale 1ns/1ps
`default_nettype none

module flmc_host_model (
  output logic sck_o,
  output logic cs_n_o,
  output logic [3:0] dq_o,
  input wire logic [3:0] dq_i
);
  initial begin
    sck_o = 1'b0;
    cs_n_o = 1'b1;
    dq_o = 4'h5;
  end
  // data set while the clock is low, sampled by the device at the rise
  task automatic tick(input logic [3:0] v);
    dq_o = v;
    #40;
    sck_o = 1'b1;
    #40;
    sck_o = 1'b0;
  endtask
  // unused lanes toggle in single mode so they never look steady
  task automatic put(input logic [7:0] b, input bit q);
    if (q) begin
      tick(b[7:4]);
      tick(b[3:0]);
    end else begin
      for (int i = 7; i >= 0; i--) tick({~dq_o[3:1], b[i]});
    end
  endtask
  task automatic get(output logic [7:0] b);
    for (int i = 0; i < 8; i++) begin
      dq_o = ~dq_o;
      #40;
      sck_o = 1'b1;
      b = {b[6:0], dq_i[1]};
      #40;
      sck_o = 1'b0;
    end
  endtask
  // small offset keeps every link change away from system clock edges
  task automatic open();
    #2;
    cs_n_o = 1'b0;
    #40;
  endtask
  // released lines show the inverse; gap leaves time for the commit
  task automatic close();
    #40;
    cs_n_o = 1'b1;
    dq_o = ~dq_o;
    #298;
  endtask
endmodule
`default_nettype wire

// ==== verif/testbench.sv ====
// self-checking bench for the flash mode entry and exit control block
`timescale 1ns/1ps
`default_nettype none
`include "flmc_defines.svh"
`define CHK(nm, exp, got) begin checks_done++; if ((got) !== (exp)) begin failures++; \
  $display("[ERR] %s expected %0h seen %0h", nm, exp, got); end end

module testbench;
  typedef struct { logic [11:0] addr; logic [31:0] data; logic err; } flmc_row_t;
  logic mclk = 1'b0, rst_n = 1'b0, hw_rst_n = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err, sck, cs_n, quad_en, cont, a4, qpi;
  logic [3:0] host_dq, dq_out, dq_oe, dq_line;
  logic [7:0] b;
  int failures = 0, checks_done = 0, cycles = 0;
  flmc_row_t rows [5] = '{'{`FLMC_REG_STATUS, 32'h0, 1'b0}, '{`FLMC_REG_CTRL, 32'h2, 1'b0},
    '{`FLMC_REG_DW15, `FLMC_SFDP_DW15, 1'b0}, '{`FLMC_REG_DW16, `FLMC_SFDP_DW16, 1'b0}, '{12'h010, 32'h0, 1'b1}};

  assign dq_line = (dq_oe & dq_out) | (~dq_oe & host_dq);
  always #5 mclk = ~mclk;

  flmc_host_model host (.sck_o(sck), .cs_n_o(cs_n), .dq_o(host_dq), .dq_i(dq_line));
  flmc_top u_flmc_top (.MCLK_I(mclk), .RST_N_I(rst_n), .HW_RST_N_I(hw_rst_n), .SCK_I(sck), .CS_N_I(cs_n),
    .DQ_I(dq_line), .DQ_O(dq_out), .DQ_OE_O(dq_oe), .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite),
    .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
    .QUAD_ENABLE_O(quad_en), .CONT_MODE_O(cont), .ADDR4_O(a4), .QPI_O(qpi));

  task automatic finish_test();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      failures++;
      finish_test();
    end
  end
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic md(input logic [3:0] e);
    `CHK("modes", e, {qpi, a4, cont, quad_en})
  endtask
  task automatic rds(input logic [7:0] o);
    host.open();
    host.put(o, 1'b0);
    host.get(b);
    host.close();
  endtask
  task automatic done(input string s);
    $display("test %s done", s);
  endtask
  task automatic frm(input logic [7:0] o, input bit q);
    host.open();
    host.put(o, q);
    host.close();
  endtask
  task automatic qrd(input logic [7:0] o, input int nib, input logic [7:0] m);
    host.open();
    if (o != 8'h00) host.put(o, 1'b0);
    repeat (nib) host.tick(4'h0);
    host.put(m, 1'b1);
    host.close();
  endtask
  task automatic fexit();
    host.open();
    repeat (8) host.tick(`FLMC_FH_NIBBLE);
    host.close();
  endtask
  task automatic wrsr(input bit we, input logic [7:0] s2);
    if (we) frm(`FLMC_OP_WREN, 1'b0);
    host.open();
    host.put(`FLMC_OP_WRSR, 1'b0);
    host.put(8'h00, 1'b0);
    host.put(s2, 1'b0);
    host.close();
  endtask
  task automatic cfg(input logic [7:0] o, input logic [7:0] d, input bit q);
    if (o == `FLMC_OP_WRCFG) frm(`FLMC_OP_WREN, q);
    host.open();
    host.put(o, q);
    host.put(8'h80, q);
    host.put(8'h00, q);
    host.put(8'h03, q);
    if (o == `FLMC_OP_WRCFG) host.put(d, q);
    else host.get(b);
    host.close();
  endtask

  initial begin
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    foreach (rows[i]) begin
      apb(1'b0, rows[i].addr, 32'h0);
      `CHK("prdata", rows[i].data, rd)
      `CHK("pslverr", rows[i].err, err)
    end
    apb(1'b1, `FLMC_REG_DW15, 32'h0);
    apb(1'b0, `FLMC_REG_DW15, 32'h0);
    `CHK("ro word", `FLMC_SFDP_DW15, rd)
    done("apb");
    frm(`FLMC_OP_EN4B, 1'b1);
    md(4'h0);
    frm(`FLMC_OP_EN4B, 1'b0);
    md(4'h4);
    frm(`FLMC_OP_RSTEN, 1'b0);
    frm(`FLMC_OP_EN4B, 1'b0);
    frm(`FLMC_OP_RST, 1'b0);
    md(4'h4);
    frm(`FLMC_OP_RSTEN, 1'b0);
    frm(`FLMC_OP_RST, 1'b0);
    md(4'h0);
    done("addressing");
    wrsr(1'b0, 8'h02);
    md(4'h0);
    wrsr(1'b1, 8'h02);
    md(4'h1);
    rds(`FLMC_OP_RDSR2);
    `CHK("status2 quad enable", 1'b1, b[`FLMC_SR2_QUAD_EN_BIT])
    frm(`FLMC_OP_WREN, 1'b0);
    rds(`FLMC_OP_RDSR1);
    `CHK("status1 wel", 1'b1, b[1])
    qrd(`FLMC_OP_QREAD, 6, `FLMC_MODE_ENTER);
    qrd(8'h00, 6, `FLMC_MODE_ENTER);
    md(4'h3);
    qrd(8'h00, 6, 8'h00);
    md(4'h1);
    qrd(`FLMC_OP_QREAD, 6, `FLMC_MODE_ENTER);
    qrd(8'h00, 6, 8'h5A);
    md(4'h1);
    frm(`FLMC_OP_EN4B, 1'b0);
    qrd(`FLMC_OP_QREAD4, 8, `FLMC_MODE_ENTER);
    md(4'h7);
    fexit();
    md(4'h5);
    frm(`FLMC_OP_EX4B, 1'b0);
    md(4'h1);
    done("continuous");
    cfg(`FLMC_OP_RDCFG, 8'h00, 1'b0);
    `CHK("config", 1'b0, b[`FLMC_CFG_QPI_BIT])
    cfg(`FLMC_OP_WRCFG, 8'h40, 1'b0);
    md(4'h9);
    cfg(`FLMC_OP_WRCFG, 8'h00, 1'b1);
    md(4'h1);
    cfg(`FLMC_OP_WRCFG, 8'h40, 1'b0);
    frm(`FLMC_OP_RSTEN, 1'b1);
    frm(`FLMC_OP_RST, 1'b1);
    md(4'h1);
    wrsr(1'b1, 8'h00);
    md(4'h0);
    done("quad protocol");
    frm(`FLMC_OP_EN4B, 1'b0);
    @(posedge mclk);
    hw_rst_n <= 1'b0;
    repeat (8) @(posedge mclk);
    hw_rst_n <= 1'b1;
    repeat (4) @(posedge mclk);
    md(4'h0);
    frm(`FLMC_OP_EN4B, 1'b0);
    apb(1'b1, `FLMC_REG_CTRL, 32'h1);
    repeat (4) @(posedge mclk);
    md(4'h0);
    apb(1'b1, `FLMC_REG_CTRL, 32'h0);
    frm(`FLMC_OP_EN4B, 1'b0);
    md(4'h0);
    apb(1'b1, `FLMC_REG_CTRL, 32'h2);
    wrsr(1'b1, 8'h02);
    cfg(`FLMC_OP_WRCFG, 8'h40, 1'b0);
    @(posedge mclk);
    rst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    md(4'h0);
    done("resets");
    finish_test();
  end
endmodule
`default_nettype wire
